// >>> plcc_top.sv
// Peer link connection supervisor: command register, link state machine, status.
//
// The plain strobed port and the address map are this design's own decisions.
`default_nettype none
// Contract
// [RULE1] Report receive timeout in ms; enforce it.
// [RULE2] Report ms waited for last answer.
// [RULE3] State code: 0 closed, 1 opening, 2 connected.
// [RULE4] Connected state exchanges data, supervises timing.
// [RULE5] Command word: 0x0000 automatic, 0x8000 disabled.
// [RULE6] Codes 0x0100 and 0x0101 select toggle phases.
// [RULE7] Automatic mode retries in next program cycle.
// [RULE8] Automatic reconnection is the reset default.
// [RULE9] Phase A holds closed until phase B.
// [RULE10] Phase B holds closed until phase A.
// [RULE11] Disabled keeps link off, no attempts.
// [RULE12] Expose a 16-bit version signature word.
// [RULE13] One attempt per toggle phase change.
module plcc_top #(
  parameter int unsigned MS_CYCLES = plcc_pkg::MS_CYCLES,
  parameter logic [15:0] VERSION   = plcc_pkg::VERSION_DEF
) (
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // Register port.
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Program cycle pacing.
  input  wire logic        cycle_tick_i,
  // Peer link events.
  input  wire logic        peer_conn_ok_i,
  input  wire logic        peer_msg_valid_i,
  input  wire logic        peer_msg_sent_i,
  input  wire logic        peer_resp_i,
  // Link control and status.
  output logic             link_open_o,
  output logic             exchange_en_o,
  output logic      [1:0]  link_state_o,
  // Interrupt.
  output logic             irq_o
);
  // ==========================================================================
  // Declarations
  // ==========================================================================
  plcc_cmd_if cmd_if ();                        // Decoded command.
  plcc_pkg::plcc_state_t state_reg;             // Link state.
  plcc_pkg::plcc_state_t state_next;            // Next link state.
  logic [15:0]           cmd_reg;               // Command word.
  logic [31:0]           rx_tmo_reg;            // Receive timeout in ms.
  logic [31:0]           rx_ms_reg;             // Ms since last valid message.
  logic [31:0]           rx_ms_next;            // Next receive silence count.
  logic [31:0]           resp_ms_reg;           // Ms waited for the last answer.
  logic [31:0]           resp_ms_next;          // Next response time.
  logic                  wait_reg;              // Waiting for an answer.
  logic                  wait_next;             // Next waiting flag.
  logic                  arm_reg;               // Toggle reconnection pending.
  logic                  arm_next;              // Next pending flag.
  logic [1:0]            irq_stat_reg;          // Sticky event bits.
  logic [1:0]            irq_stat_next;         // Next sticky bits.
  logic [1:0]            irq_en_reg;            // Interrupt enables.
  logic [31:0]           rdata_reg;             // Read data register.
  logic [31:0]           rd_mux;                // Selected read value.
  logic [1:0]            events;                // Events raised this cycle.
  logic [1:0]            irq_clr;               // Clear mask written this cycle.
  logic                  ms_tick;               // One-ms pulse.
  logic                  rx_expired;            // Receive timeout reached.
  logic                  disabled;              // Disable command in force.
  logic                  toggling;              // A toggle mode is in force.
  logic                  may_open;              // An attempt may start now.
  logic                  entering;              // State changes this cycle.
  logic                  wr_cmd;                // Write to command register.
  logic                  wr_tmo;                // Write to receive timeout.
  logic                  wr_clr;                // Write to interrupt clear.
  logic                  wr_en;                 // Write to interrupt enable.

  // ==========================================================================
  // Submodules
  // ==========================================================================
  // The prescaler turns the system clock into a millisecond tick.
  plcc_ms_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_ms_timer (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ms_tick_o (ms_tick)
  );

  // The decoder maps the command word to a mode and spots phase changes.
  plcc_cmd_decode u_cmd_decode (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .cmd_i     (cmd_reg),    // see [RULE5] see [RULE6]
    .cmd_if    (cmd_if)
  );

  // ==========================================================================
  // Register decode
  // ==========================================================================
  assign wr_cmd  = wr_i && (addr_i == plcc_pkg::OFS_CMD);
  assign wr_tmo  = wr_i && (addr_i == plcc_pkg::OFS_RX_TMO);
  assign wr_clr  = wr_i && (addr_i == plcc_pkg::OFS_IRQ_CLR);
  assign wr_en   = wr_i && (addr_i == plcc_pkg::OFS_IRQ_EN);
  assign irq_clr = wr_clr ? wdata_i[1:0] : 2'h0;

  // Unmapped and write-only offsets read as zero.
  assign rd_mux =
    (addr_i == plcc_pkg::OFS_CMD)      ? {16'h0000, cmd_reg}       :
    (addr_i == plcc_pkg::OFS_RX_TMO)   ? rx_tmo_reg                : // see [RULE1]
    (addr_i == plcc_pkg::OFS_RESP_MS)  ? resp_ms_reg               : // see [RULE2]
    (addr_i == plcc_pkg::OFS_STATE)    ? {30'h0, state_reg}        : // see [RULE3]
    (addr_i == plcc_pkg::OFS_VERSION)  ? {16'h0000, VERSION}       : // see [RULE12]
    (addr_i == plcc_pkg::OFS_IRQ_STAT) ? {30'h0, irq_stat_reg}     :
    (addr_i == plcc_pkg::OFS_IRQ_EN)   ? {30'h0, irq_en_reg}       : 32'h0000_0000;

  // Software registers; the command resets to automatic reconnection.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cmd_reg    <= plcc_pkg::CMD_RST;                // see [RULE8]
      rx_tmo_reg <= plcc_pkg::RX_TMO_RST;
      irq_en_reg <= 2'h0;
      rdata_reg  <= 32'h0000_0000;
    end else begin
      if (wr_cmd) begin
        cmd_reg <= wdata_i[15:0];                     // see [RULE5]
      end
      if (wr_tmo) begin
        rx_tmo_reg <= wdata_i;
      end
      if (wr_en) begin
        irq_en_reg <= wdata_i[1:0];
      end
      // Read data stands only in the cycle after the strobe.
      rdata_reg <= rd_i ? rd_mux : 32'h0000_0000;
    end
  end

  assign rdata_o = rdata_reg;

  // ==========================================================================
  // Link state machine
  // ==========================================================================
  assign disabled   = (cmd_if.mode == plcc_pkg::MODE_DIS);
  assign toggling   = (cmd_if.mode == plcc_pkg::MODE_TOG_A) ||
                      (cmd_if.mode == plcc_pkg::MODE_TOG_B);
  assign rx_expired = (rx_ms_reg >= rx_tmo_reg);      // see [RULE1]
  // Attempts are paced by the program cycle tick, never by the raw clock.
  assign may_open   = cycle_tick_i &&
                      ((cmd_if.mode == plcc_pkg::MODE_AUTO) || (toggling && arm_reg));

  // Next state: the disable command overrides everything else.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      plcc_pkg::ST_CLOSED: begin
        if (may_open) begin
          state_next = plcc_pkg::ST_OPENING;          // see [RULE7] see [RULE9] see [RULE10]
        end
      end
      plcc_pkg::ST_OPENING: begin
        if (disabled || rx_expired) begin
          state_next = plcc_pkg::ST_CLOSED;           // see [RULE11]
        end else if (peer_conn_ok_i) begin
          state_next = plcc_pkg::ST_CONNECTED;
        end
      end
      plcc_pkg::ST_CONNECTED: begin
        if (disabled || rx_expired) begin
          state_next = plcc_pkg::ST_CLOSED;           // see [RULE1] see [RULE11]
        end
      end
      default: begin
        state_next = plcc_pkg::ST_CLOSED;
      end
    endcase
  end

  assign entering = (state_next != state_reg);

  // A phase change arms one attempt; the attempt consumes it.
  assign arm_next = !toggling ? 1'b0 :
                    cmd_if.reconnect ? 1'b1 :         // see [RULE13]
                    (state_reg == plcc_pkg::ST_CLOSED && may_open) ? 1'b0 : arm_reg;

  // The state register holds the reported code directly.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= plcc_pkg::ST_CLOSED;
      arm_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      arm_reg   <= arm_next;
    end
  end

  assign link_state_o  = state_reg;                              // see [RULE3]
  assign link_open_o   = (state_reg == plcc_pkg::ST_OPENING);
  assign exchange_en_o = (state_reg == plcc_pkg::ST_CONNECTED);  // see [RULE4]

  // ==========================================================================
  // Time supervision
  // ==========================================================================
  // Silence restarts at every state change and every valid message.
  // The counts saturate so a stuck link cannot wrap back under the timeout.
  assign rx_ms_next =
    (entering || peer_msg_valid_i || state_reg == plcc_pkg::ST_CLOSED) ? 32'h0 :
    (ms_tick && rx_ms_reg != 32'hffff_ffff) ? rx_ms_reg + 32'h1 : rx_ms_reg;
  assign wait_next =
    (state_reg != plcc_pkg::ST_CONNECTED) ? 1'b0 :
    peer_msg_sent_i ? 1'b1 : peer_resp_i ? 1'b0 : wait_reg;
  assign resp_ms_next =
    (peer_msg_sent_i && state_reg == plcc_pkg::ST_CONNECTED) ? 32'h0 :
    (wait_reg && ms_tick && resp_ms_reg != 32'hffff_ffff) ? resp_ms_reg + 32'h1 :
    resp_ms_reg;

  // Response time keeps its last value once the answer has come.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_ms_reg   <= 32'h0000_0000;
      resp_ms_reg <= 32'h0000_0000;
      wait_reg    <= 1'b0;
    end else begin
      rx_ms_reg   <= rx_ms_next;                      // see [RULE4]
      resp_ms_reg <= resp_ms_next;                    // see [RULE2]
      wait_reg    <= wait_next;
    end
  end

  // ==========================================================================
  // Interrupts
  // ==========================================================================
  assign events[plcc_pkg::IRQ_UP]   = entering && (state_next == plcc_pkg::ST_CONNECTED);
  assign events[plcc_pkg::IRQ_LOST] = (state_reg == plcc_pkg::ST_CONNECTED) &&
                                      (state_next == plcc_pkg::ST_CLOSED);
  // A new event in the clearing cycle wins over the clear.
  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | events;

  // Sticky status bits.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_stat_reg <= 2'h0;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  assign irq_o = |(irq_stat_reg & irq_en_reg);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_closed_tick_auto;
    state_reg == plcc_pkg::ST_CLOSED && cmd_if.mode == plcc_pkg::MODE_AUTO && cycle_tick_i;
  endsequence
  sequence s_opening_now;
    state_reg == plcc_pkg::ST_OPENING;
  endsequence

  property p_state_code;
    @(posedge clk_sys_i) disable iff (rst_i)
      link_state_o != 2'h3 && (link_open_o == (link_state_o == 2'h1));
  endproperty
  a_state_code: assert property (p_state_code) else $error("Bad link state code."); // see [RULE3]

  property p_auto_retry;
    @(posedge clk_sys_i) disable iff (rst_i)
      s_closed_tick_auto |=> s_opening_now;
  endproperty
  a_auto_retry: assert property (p_auto_retry) else $error("No automatic retry."); // see [RULE7]

  property p_reset_auto;
    @(posedge clk_sys_i) rst_i |=> cmd_reg == 16'h0000 ##1 cmd_if.mode == plcc_pkg::MODE_AUTO;
  endproperty
  a_reset_auto: assert property (p_reset_auto) else $error("Reset mode not auto."); // see [RULE8]

  property p_tog_a_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
      state_reg == plcc_pkg::ST_CLOSED && cmd_if.mode == plcc_pkg::MODE_TOG_A &&
      !arm_reg |=> state_reg == plcc_pkg::ST_CLOSED;
  endproperty
  a_tog_a_hold: assert property (p_tog_a_hold) else $error("Phase A reopened."); // see [RULE9]

  property p_tog_b_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
      state_reg == plcc_pkg::ST_CLOSED && cmd_if.mode == plcc_pkg::MODE_TOG_B &&
      !arm_reg |=> state_reg == plcc_pkg::ST_CLOSED;
  endproperty
  a_tog_b_hold: assert property (p_tog_b_hold) else $error("Phase B reopened."); // see [RULE10]

  property p_tog_once;
    @(posedge clk_sys_i) disable iff (rst_i)
      state_reg == plcc_pkg::ST_CLOSED && toggling && arm_reg && cycle_tick_i
      |=> s_opening_now ##0 !arm_reg;
  endproperty
  a_tog_once: assert property (p_tog_once) else $error("Toggle attempt not single."); // see [RULE13]

  property p_disabled_off;
    @(posedge clk_sys_i) disable iff (rst_i)
      disabled [*2] |-> state_reg == plcc_pkg::ST_CLOSED && !exchange_en_o;
  endproperty
  a_disabled_off: assert property (p_disabled_off) else $error("Link on while disabled."); // see [RULE11]

  property p_rx_loss;
    @(posedge clk_sys_i) disable iff (rst_i)
      exchange_en_o && rx_ms_reg >= rx_tmo_reg |=> state_reg == plcc_pkg::ST_CLOSED;
  endproperty
  a_rx_loss: assert property (p_rx_loss) else $error("Receive timeout missed."); // see [RULE1]

  property p_resp_count;
    @(posedge clk_sys_i) disable iff (rst_i)
      wait_reg && ms_tick && !peer_msg_sent_i && resp_ms_reg != 32'hffff_ffff
      |=> resp_ms_reg == $past(resp_ms_reg) + 32'h1;
  endproperty
  a_resp_count: assert property (p_resp_count) else $error("Response time stalled."); // see [RULE2]

  property p_version;
    @(posedge clk_sys_i) disable iff (rst_i)
      rd_i && addr_i == plcc_pkg::OFS_VERSION |=> rdata_o == {16'h0000, VERSION};
  endproperty
  a_version: assert property (p_version) else $error("Version read wrong."); // see [RULE12]

  property p_exchange;
    @(posedge clk_sys_i) disable iff (rst_i)
      $rose(exchange_en_o) |-> $past(link_open_o) && $past(peer_conn_ok_i);
  endproperty
  a_exchange: assert property (p_exchange) else $error("Exchange without opening."); // see [RULE4]

  // A lost link must leave its sticky bit behind, or software never learns of it.
  property p_lost_flag;
    @(posedge clk_sys_i) disable iff (rst_i)
      exchange_en_o ##1 state_reg == plcc_pkg::ST_CLOSED
      |-> irq_stat_reg[plcc_pkg::IRQ_LOST];
  endproperty
  a_lost_flag: assert property (p_lost_flag) else $error("Link loss not flagged.");

  // Read data must fall back to zero, so a stale word never looks like an answer.
  property p_rdata_idle;
    @(posedge clk_sys_i) disable iff (rst_i)
      !rd_i |=> rdata_o == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data lingered.");
endmodule
`default_nettype wire

// >>> plcc_pkg.sv
// Shared constants and types for the peer link connection control block.
`default_nettype none
package plcc_pkg;
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 50;        // System clock period in ns.
  localparam int unsigned MS_NS         = 1000000;   // One millisecond in ns.
  localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS; // Cycles per ms.
  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [7:0] OFS_CMD      = 8'h00;      // Connection command word, read/write.
  localparam logic [7:0] OFS_RX_TMO   = 8'h04;      // Receive timeout in ms, read/write.
  localparam logic [7:0] OFS_RESP_MS  = 8'h08;      // Response time in ms, read only.
  localparam logic [7:0] OFS_STATE    = 8'h0c;      // Link state code, read only.
  localparam logic [7:0] OFS_VERSION  = 8'h10;      // Version signature, read only.
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;      // Sticky event bits, read only.
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h18;      // Write one to clear, write only.
  localparam logic [7:0] OFS_IRQ_EN   = 8'h1c;      // Interrupt enables, read/write.
  // ==========================================================================
  // Command codes and reset values
  // ==========================================================================
  localparam logic [15:0] CMD_AUTO    = 16'h0000;   // Automatic reconnection.
  localparam logic [15:0] CMD_TOG_A   = 16'h0100;   // Toggle reconnection, phase A.
  localparam logic [15:0] CMD_TOG_B   = 16'h0101;   // Toggle reconnection, phase B.
  localparam logic [15:0] CMD_DIS     = 16'h8000;   // Link disabled.
  localparam logic [15:0] CMD_RST     = CMD_AUTO;   // Command after reset.
  localparam logic [31:0] RX_TMO_RST  = 32'h0000_0064; // Receive timeout after reset.
  localparam logic [15:0] VERSION_DEF = 16'h5a01;   // Arbitrary signature value.
  localparam int unsigned IRQ_W       = 2;          // Number of interrupt events.
  localparam int unsigned IRQ_UP      = 0;          // Bit: link established.
  localparam int unsigned IRQ_LOST    = 1;          // Bit: link lost.
  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_CLOSED    = 2'h0,
    ST_OPENING   = 2'h1,
    ST_CONNECTED = 2'h2
  } plcc_state_t;                                   // Codes are the reported link state.
  typedef enum logic [1:0] {MODE_AUTO, MODE_TOG_A, MODE_TOG_B, MODE_DIS} plcc_mode_t;
endpackage
`default_nettype wire

// >>> plcc_cmd_if.sv
// Interface carrying the decoded connection command between modules.
`default_nettype none
interface plcc_cmd_if;
  plcc_pkg::plcc_mode_t mode;      // Decoded command mode in force.
  logic                 reconnect; // One-cycle pulse on a toggle phase change.
  modport dec  (output mode, output reconnect);
  modport core (input mode, input reconnect);
endinterface
`default_nettype wire

// >>> plcc_ms_timer.sv
// Millisecond tick generator for the peer link connection control block.
`default_nettype none
module plcc_ms_timer #(
  parameter int unsigned MS_CYCLES = plcc_pkg::MS_CYCLES
) (
  // Clock and reset.
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // Tick output.
  output logic      ms_tick_o
);
  // ==========================================================================
  // Prescaler
  // ==========================================================================
  logic [15:0] cnt_reg;  // Cycles counted within the current millisecond.
  logic [15:0] cnt_next; // Next prescaler count.
  logic        wrap;     // Last cycle of the millisecond.

  assign wrap      = (cnt_reg == 16'(MS_CYCLES - 1));
  assign cnt_next  = wrap ? 16'h0000 : cnt_reg + 16'h0001;
  assign ms_tick_o = wrap;

  // The count restarts on reset so the first tick comes one full ms later.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// >>> plcc_cmd_decode.sv
// Connection command decoder with toggle phase change detection.
`default_nettype none
module plcc_cmd_decode (
  // Clock and reset.
  input  wire logic  clk_sys_i,
  input  wire logic  rst_i,
  // Command word from the register file.
  input  wire logic [15:0] cmd_i,
  // Decoded command.
  plcc_cmd_if.dec    cmd_if
);
  // ==========================================================================
  // Decode
  // ==========================================================================
  plcc_pkg::plcc_mode_t mode_reg;       // Mode in force.
  plcc_pkg::plcc_mode_t mode_next;      // Mode after this cycle.
  logic                 reconnect_reg;  // Phase change pulse.
  logic                 reconnect_next; // Next phase change pulse.

  // An unknown code leaves the previous mode in force rather than guessing.
  assign mode_next = (cmd_i == plcc_pkg::CMD_AUTO)  ? plcc_pkg::MODE_AUTO  :
                     (cmd_i == plcc_pkg::CMD_TOG_A) ? plcc_pkg::MODE_TOG_A :
                     (cmd_i == plcc_pkg::CMD_TOG_B) ? plcc_pkg::MODE_TOG_B :
                     (cmd_i == plcc_pkg::CMD_DIS)   ? plcc_pkg::MODE_DIS   : mode_reg;
  // Only a change between the two phases counts; holding one phase does not.
  assign reconnect_next =
    ((mode_reg == plcc_pkg::MODE_TOG_A) && (mode_next == plcc_pkg::MODE_TOG_B)) ||
    ((mode_reg == plcc_pkg::MODE_TOG_B) && (mode_next == plcc_pkg::MODE_TOG_A));

  assign cmd_if.mode      = mode_reg;
  assign cmd_if.reconnect = reconnect_reg;

  // Automatic reconnection is the mode after reset.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_reg      <= plcc_pkg::MODE_AUTO;
      reconnect_reg <= 1'b0;
    end else begin
      mode_reg      <= mode_next;
      reconnect_reg <= reconnect_next;
    end
  end
endmodule
`default_nettype wire

// >>> plcc_peer_model.sv
// Behavioural peer controller facing the connection supervisor.
`default_nettype none
module plcc_peer_model (
  // Clock and reset.
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // Link status from the device and bench controls.
  input  wire logic       link_open_i,
  input  wire logic       exchange_en_i,
  input  wire logic       mute_i,
  input  wire logic [3:0] dly_i,
  // Events towards the device.
  output logic            conn_ok_o,
  output logic            msg_valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_reg; // Cycles spent in opening or connected.
  // ==========================================================================
  // Answers
  // ==========================================================================
  // A muted peer stays silent, so the device only ever sees its own timeouts.
  always_ff @(posedge clk_sys_i) begin
    cnt_reg     <= (rst_i || !(link_open_i || exchange_en_i)) ? 4'h0 : cnt_reg + 4'h1;
    conn_ok_o   <= !rst_i && !mute_i && link_open_i && cnt_reg == dly_i;
    msg_valid_o <= !rst_i && !mute_i && exchange_en_i && cnt_reg[1:0] == 2'h3;
  end
endmodule
`default_nettype wire

// >>> plcc_top_tb.sv
// Self-checking bench for the peer link connection supervisor.
`default_nettype none
module plcc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        clk_sys_i = 1'b0;  // Clock of 50 ns.
  logic        rst_i     = 1'b1;  // Held for four cycles.
  logic        wr_i      = 1'b0;  // Register strobes.
  logic        rd_i      = 1'b0;
  logic        tick      = 1'b0;  // Program cycle, every eighth clock.
  logic        sent      = 1'b0;  // Local transmit event.
  logic        resp      = 1'b0;  // Answer event.
  logic        mute      = 1'b1;  // Silences the peer.
  logic [3:0]  dly       = 4'h0;  // Peer handshake delay.
  logic [7:0]  addr_i    = 8'h00;
  logic [31:0] wdata_i   = 32'h0;
  logic [31:0] rdata_o;
  logic        conn_ok, msg_valid, link_open_o, exch, irq;
  logic [1:0]  link_state_o;
  int          bad_count = 0, total_checks = 0, cyc = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  // Program cycle pacing, free running.
  always @(posedge clk_sys_i) begin
    cyc  <= cyc + 1;
    tick <= (cyc % 8 == 7);
  end
  plcc_top #(.MS_CYCLES(4)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cycle_tick_i(tick),
    .peer_conn_ok_i(conn_ok), .peer_msg_valid_i(msg_valid), .peer_msg_sent_i(sent),
    .peer_resp_i(resp), .link_open_o(link_open_o), .exchange_en_o(exch),
    .link_state_o(link_state_o), .irq_o(irq));
  plcc_peer_model u_peer (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link_open_i(link_open_o),
    .exchange_en_i(exch), .mute_i(mute), .dly_i(dly), .conn_ok_o(conn_ok),
    .msg_valid_o(msg_valid));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic test_done();
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe.
  task automatic rdv(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rdv(a, v);
    chk(v, exp);
  endtask
  // Bounded wait for a state code; running out ends the run.
  task automatic wait_st(input logic [1:0] s, input int n);
    for (int i = 0; i < n && link_state_o !== s; i++) @(posedge clk_sys_i) #1;
    chk({30'h0, link_state_o}, {30'h0, s});
    if (link_state_o !== s) test_done();
  endtask
  // No opening attempt may show for n cycles.
  task automatic quiet(input int n);
    repeat (n) @(posedge clk_sys_i) #1 chk({31'h0, link_open_o}, 32'h0);
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    rd(plcc_pkg::OFS_CMD, {16'h0, plcc_pkg::CMD_RST});
    rd(plcc_pkg::OFS_STATE, 32'h0);
    rd(plcc_pkg::OFS_VERSION, {16'h0, plcc_pkg::VERSION_DEF});
    rd(plcc_pkg::OFS_RX_TMO, plcc_pkg::RX_TMO_RST);
    rd(8'h20, 32'h0);
  endtask
  // Slow peer, then loss: the retry comes at the next program cycle.
  task automatic t_auto();
    wr(plcc_pkg::OFS_RX_TMO, 32'h3);
    rd(plcc_pkg::OFS_RX_TMO, 32'h3);
    wr(plcc_pkg::OFS_IRQ_EN, 32'h3);
    dly <= 4'h9;
    mute <= 1'b0;
    wait_st(2'h2, 80);
    chk({31'h0, exch}, 32'h1);
    wr(plcc_pkg::OFS_IRQ_CLR, 32'h3);
    rd(plcc_pkg::OFS_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    mute <= 1'b1;
    wait_st(2'h0, 40);
    wait_st(2'h1, 10);
    rd(plcc_pkg::OFS_IRQ_STAT, 32'h2);
    chk({31'h0, irq}, 32'h1);
  endtask
  // Response wait of 13 cycles spans three or four ms ticks and then holds.
  task automatic t_resp();
    logic [31:0] v, w;
    dly <= 4'h0;
    mute <= 1'b0;
    wait_st(2'h2, 60);
    @(posedge clk_sys_i) sent <= 1'b1;
    @(posedge clk_sys_i) sent <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
    resp <= 1'b1;
    @(posedge clk_sys_i) resp <= 1'b0;
    rdv(plcc_pkg::OFS_RESP_MS, v);
    chk({31'h0, v == 32'h3 || v == 32'h4}, 32'h1);
    rdv(plcc_pkg::OFS_RESP_MS, w);
    chk(w, v);
  endtask
  task automatic t_toggle();
    wr(plcc_pkg::OFS_CMD, {16'h0, plcc_pkg::CMD_TOG_A});
    rd(plcc_pkg::OFS_CMD, {16'h0, plcc_pkg::CMD_TOG_A});
    mute <= 1'b1;
    wait_st(2'h0, 40);
    quiet(40);
    wr(plcc_pkg::OFS_CMD, {16'h0, plcc_pkg::CMD_TOG_B});
    wait_st(2'h1, 20);
    wait_st(2'h0, 40);
    quiet(40);
    mute <= 1'b0;
    wr(plcc_pkg::OFS_CMD, {16'h0, plcc_pkg::CMD_TOG_A});
    wait_st(2'h2, 60);
  endtask
  task automatic t_dis();
    wr(plcc_pkg::OFS_CMD, {16'h0, plcc_pkg::CMD_DIS});
    wait_st(2'h0, 6);
    quiet(40);
    wr(plcc_pkg::OFS_CMD, {16'h0, plcc_pkg::CMD_AUTO});
    wait_st(2'h2, 60);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset();
    t_auto();
    t_resp();
    t_toggle();
    t_dis();
    test_done();
  end
endmodule
`default_nettype wire
